// ---- verilog/dssq_pkg.sv ----
// Constants and carrier types of the start/stop and quick stop command logic
package dssq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ    = 20;
    localparam int TICK_TIME_US    = 5000;
    localparam int TICK_CYC        = TICK_TIME_US * CLK_FREQ_MHZ;
    localparam int TICK_MS         = TICK_TIME_US / 1000;
    localparam int SUP_WIN_MS      = 100;
    localparam int SUP_WIN_TICKS   = SUP_WIN_MS / TICK_MS;
    // Least falling rate, 0,50 Hz/s, in 0.01 Hz per second
    localparam int FREQ_RATE_CHZ_S = 50;
    localparam int FREQ_DROP_CHZ   = FREQ_RATE_CHZ_S * SUP_WIN_MS / 1000;
    localparam int TCNT_W          = 17;
    localparam int VAL_W           = 16;
    localparam logic [VAL_W-1:0] SUP_WIN_LIM = VAL_W'(SUP_WIN_TICKS);
    localparam logic [VAL_W-1:0] FREQ_DROP   = VAL_W'(FREQ_DROP_CHZ);

    // ------------------------------------------------------------------
    // Encodings and field positions
    // ------------------------------------------------------------------
    localparam logic [2:0] SCHEME_FWD_REV                 = 3'h0;
    localparam logic [2:0] SCHEME_RUN_DIR                 = 3'h1;
    localparam logic [2:0] SCHEME_RUN_ENABLE              = 3'h2;
    localparam logic [2:0] SCHEME_THREE_WIRE_PULSE        = 3'h3;
    localparam logic [2:0] SCHEME_RUN_PLUS_POT_RAISE      = 3'h4;
    localparam logic [2:0] SCHEME_DUAL_DIRECTION_EDGE     = 3'h5;
    localparam logic [2:0] SCHEME_EDGE_RUN_PLUS_DIRECTION = 3'h6;

    localparam logic [1:0] SUP_BOTH = 2'h0;
    localparam logic [1:0] SUP_FREQ = 2'h1;
    localparam logic [1:0] SUP_ACK  = 2'h2;
    localparam logic [1:0] SUP_NONE = 2'h3;

    localparam logic [1:0] QS_MODE_RAMP   = 2'h1;
    localparam logic [1:0] QS_MODE_LIMITS = 2'h3;

    localparam int ACK_BIT = 15;
    localparam int DIN_W   = 7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        QS_IDLE   = 5'h01,
        QS_DELAY  = 5'h02,
        QS_WATCH  = 5'h04,
        QS_BYPASS = 5'h08,
        QS_OWN    = 5'h10
    } dssq_qs_state_t;

    typedef struct packed {
        logic first_run_input;
        logic second_run_input;
        logic reverse;
        logic run_enable;
        logic quick_stop;
        logic fault_reset;
        logic place_change;
    } dssq_din_t;

    typedef struct packed {
        logic [2:0]       run_scheme;
        logic [1:0]       quick_stop_mode;
        logic [1:0]       stop_supervision_select;
        logic [VAL_W-1:0] stop_input_delay;
        logic [VAL_W-1:0] stop_ack_timeout;
        logic [VAL_W-1:0] emergency_ramp_time;
        logic [VAL_W-1:0] emergency_power_cap;
        logic [VAL_W-1:0] emergency_torque_cap;
    } dssq_cfg_t;

    typedef struct packed {
        logic [VAL_W-1:0] out_freq;
        logic [VAL_W-1:0] aux_cmd_word;
    } dssq_drv_t;

    typedef struct packed {
        logic             run_request;
        logic             reverse;
        logic             pot_raise;
        logic             start_inhibit;
        logic             qs_pending;
        logic             qs_bypass;
        logic             qs_own;
        logic             force_speed_ctrl;
        logic             ramp_sel;
        logic             limit_sel;
        logic [VAL_W-1:0] ramp_time;
        logic [VAL_W-1:0] power_lim;
        logic [VAL_W-1:0] torque_lim;
    } dssq_cmd_t;

    typedef struct packed {
        logic [DIN_W-1:0] s1;
        logic [DIN_W-1:0] s2;
        logic [DIN_W-1:0] prev;
    } dssq_sync_t;

    typedef struct packed {
        logic [TCNT_W-1:0] cnt;
        logic              tick;
    } dssq_div_t;

endpackage

// ---- verilog/dssq_in_sync.sv ----
// Digital input synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module dssq_in_sync
    import dssq_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire logic      sys_rst_i,
    input  wire dssq_din_t din_i,
    output dssq_din_t      lvl_o,
    output dssq_din_t      rise_o,
    output dssq_din_t      fall_o
);

    dssq_sync_t st_r;
    dssq_sync_t st_nxt;

    // ------------------------------------------------------------------
    // Two-stage synchroniser; s1 feeds only s2
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.s1   = din_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign lvl_o  = st_r.s2;
    assign rise_o = st_r.s2 & ~st_r.prev; // R21
    assign fall_o = ~st_r.s2 & st_r.prev; // R21

endmodule

// ---- verilog/dssq_tick_div.sv ----
// Divider that makes the one-cycle control tick enable
`timescale 1ns/1ps
module dssq_tick_div
    import dssq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    output logic      tick_o
);

    localparam logic [TCNT_W-1:0] LAST = TCNT_W'(TICK_CYCLES - 1);

    dssq_div_t st_r;
    dssq_div_t st_nxt;

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt >= LAST)
        begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end
        else
            st_nxt.cnt = st_r.cnt + 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick_o = st_r.tick;

endmodule

// ---- verilog/dssq_core.sv ----
// Start/stop input decoding and quick stop supervision of a motor drive
//
// Summary of operation
// R01: Ramp stop mode uses emergency ramp time
// R02: Function 3 applies emergency power/torque caps
// R03: Wait stop input delay before stopping
// R04: Ack timeout unmet: speed control, own stop
// R05: Bypass own stop while upper system handles
// R06: Select 0 both, 1 frequency, 2 ack
// R07: Upper system acknowledges with aux bit 15
// R08: Select 3 stops at once, no checks
// R09: Slow falling over 100 ms: own stop
// R10: Frequency change evaluated every 5 ms tick
// R11: Scheme 0: inputs start forward / reverse
// R12: Scheme 0: first selected direction wins
// R13: Scheme 1: run/stop plus reverse/forward
// R14: Scheme 2: run plus run enable input
// R15: Scheme 3: start pulse, stop falling edge
// R16: Scheme 4: start forward, pot raise
// R17: Scheme 5: rising edges start forward/reverse
// R18: Scheme 6: edge start, level direction
// R19: Edge schemes need start input opened first
// R20: Separate reverse input where scheme lacks one
// R21: Inputs synchronised, edges from sample pairs
`timescale 1ns/1ps
module dssq_core
    import dssq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    input  wire logic      clk_sys_i,
    input  wire logic      sys_rst_i,
    input  wire dssq_din_t din_i,
    input  wire dssq_cfg_t cfg_i,
    input  wire dssq_drv_t drv_i,
    output dssq_cmd_t      cmd_o,
    output logic           tick_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dssq_qs_state_t   qs;
        logic [VAL_W-1:0] tmr;
        logic [VAL_W-1:0] win;
        logic [VAL_W-1:0] fref;
        logic             fdrop_seen;
        logic             ffail;
        logic             run;
        logic             rev;
        logic             interlock;
        dssq_cmd_t        cmd;
    } dssq_st_t;

    dssq_st_t  st_r;
    dssq_st_t  st_nxt;
    dssq_din_t lvl;
    dssq_din_t rise;
    dssq_din_t fall;
    logic      tick;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic sup_met(input logic [1:0] sel,
                                     input logic       ack,
                                     input logic       fok);
        logic res;
        res = 1'b0;
        case (sel)
            SUP_BOTH: res = ack & fok;
            SUP_FREQ: res = fok;
            SUP_ACK:  res = ack;
            default:  res = 1'b0;
        endcase
        return res; // R06
    endfunction

    function automatic logic sup_uses_freq(input logic [1:0] sel);
        return (sel == SUP_BOTH) || (sel == SUP_FREQ);
    endfunction

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    dssq_in_sync u_sync
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .din_i     (din_i),
        .lvl_o     (lvl),
        .rise_o    (rise),
        .fall_o    (fall)
    );

    dssq_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .tick_o    (tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic             ack;
    logic             fok;
    logic             met;
    logic [VAL_W-1:0] freq;

    assign ack  = drv_i.aux_cmd_word[ACK_BIT]; // R07
    assign freq = drv_i.out_freq;
    assign fok  = st_r.fdrop_seen & ~st_r.ffail;
    assign met  = sup_met(cfg_i.stop_supervision_select, ack, fok);

    always_comb
    begin
        st_nxt = st_r;

        // Frequency supervision; zero speed counts as reached
        if (tick && (st_r.qs == QS_WATCH || st_r.qs == QS_BYPASS)) // R10
        begin
            if (freq == '0 ||
                (st_r.fref >= freq && (st_r.fref - freq) >= FREQ_DROP))
            begin
                st_nxt.fref       = freq;
                st_nxt.win        = '0;
                st_nxt.fdrop_seen = 1'b1;
            end
            else if (st_r.win >= SUP_WIN_LIM - 1'b1)
                st_nxt.ffail = 1'b1; // R09
            else
                st_nxt.win = st_r.win + 1'b1;
        end

        // Quick stop sequence
        case (st_r.qs)
            QS_IDLE:
            begin
                st_nxt.tmr = '0;
                if (lvl.quick_stop)
                    st_nxt.qs = QS_DELAY;
            end
            QS_DELAY:
            begin
                if (st_r.tmr >= cfg_i.stop_input_delay) // R03
                begin
                    st_nxt.tmr        = '0;
                    st_nxt.win        = '0;
                    st_nxt.fref       = freq;
                    st_nxt.fdrop_seen = 1'b0;
                    st_nxt.ffail      = 1'b0;
                    if (cfg_i.stop_supervision_select == SUP_NONE)
                        st_nxt.qs = QS_OWN; // R08
                    else
                        st_nxt.qs = QS_WATCH;
                end
                else if (tick)
                    st_nxt.tmr = st_r.tmr + 1'b1;
            end
            QS_WATCH:
            begin
                if (st_r.ffail && sup_uses_freq(cfg_i.stop_supervision_select))
                    st_nxt.qs = QS_OWN; // R09
                else if (met)
                    st_nxt.qs = QS_BYPASS; // R05
                else if (st_r.tmr >= cfg_i.stop_ack_timeout)
                    st_nxt.qs = QS_OWN; // R04
                else if (tick)
                    st_nxt.tmr = st_r.tmr + 1'b1;
            end
            QS_BYPASS:
            begin
                // Upper system lost control of the stop: take it over
                if (!met)
                    st_nxt.qs = QS_OWN; // R05
            end
            QS_OWN:
            begin
                st_nxt.qs = QS_OWN;
            end
            default:
            begin
                st_nxt.qs = QS_IDLE;
            end
        endcase
        if (!lvl.quick_stop)
            st_nxt.qs = QS_IDLE;

        // Start interlock of the edge schemes
        if (!st_r.interlock)
        begin
            if (rise.fault_reset || !lvl.run_enable || rise.place_change)
                st_nxt.interlock = 1'b1; // R19
        end
        else if (cfg_i.run_scheme == SCHEME_DUAL_DIRECTION_EDGE)
        begin
            if (!lvl.first_run_input && !lvl.second_run_input)
                st_nxt.interlock = 1'b0; // R19
        end
        else if (!lvl.first_run_input)
            st_nxt.interlock = 1'b0; // R19

        // Run and direction decode
        st_nxt.rev = lvl.reverse; // R20
        case (cfg_i.run_scheme)
            SCHEME_FWD_REV:
            begin
                if (!lvl.first_run_input && !lvl.second_run_input)
                    st_nxt.run = 1'b0;
                else if (lvl.first_run_input && lvl.second_run_input)
                begin
                    // Direction already running is kept
                    st_nxt.rev = st_r.rev; // R12
                    if (!st_r.run)
                    begin
                        st_nxt.run = 1'b1;
                        st_nxt.rev = 1'b0;
                    end
                end
                else
                begin
                    st_nxt.run = 1'b1; // R11
                    st_nxt.rev = lvl.second_run_input; // R11
                end
            end
            SCHEME_RUN_DIR:
            begin
                st_nxt.run = lvl.first_run_input; // R13
                st_nxt.rev = lvl.second_run_input; // R13
            end
            SCHEME_RUN_ENABLE:
            begin
                st_nxt.run = lvl.first_run_input & lvl.second_run_input; // R14
            end
            SCHEME_THREE_WIRE_PULSE:
            begin
                // Stop edge wins over a coincident start pulse
                if (fall.second_run_input || !lvl.second_run_input)
                    st_nxt.run = 1'b0; // R15
                else if (rise.first_run_input)
                    st_nxt.run = 1'b1; // R15
            end
            SCHEME_RUN_PLUS_POT_RAISE:
            begin
                st_nxt.run = lvl.first_run_input; // R16
            end
            SCHEME_DUAL_DIRECTION_EDGE:
            begin
                st_nxt.rev = st_r.rev;
                if (!st_r.run)
                begin
                    if (rise.first_run_input && !st_r.interlock)
                    begin
                        st_nxt.run = 1'b1; // R17
                        st_nxt.rev = 1'b0;
                    end
                    else if (rise.second_run_input && !st_r.interlock)
                    begin
                        st_nxt.run = 1'b1; // R17
                        st_nxt.rev = 1'b1;
                    end
                end
                else if ((!st_r.rev && !lvl.first_run_input) ||
                         (st_r.rev && !lvl.second_run_input))
                    st_nxt.run = 1'b0;
            end
            SCHEME_EDGE_RUN_PLUS_DIRECTION:
            begin
                st_nxt.rev = lvl.second_run_input; // R18
                if (!lvl.first_run_input)
                    st_nxt.run = 1'b0; // R18
                else if (rise.first_run_input && !st_r.interlock)
                    st_nxt.run = 1'b1; // R18
            end
            default:
            begin
                st_nxt.run = 1'b0;
            end
        endcase
        // Run enable removal always stops
        if (!lvl.run_enable)
            st_nxt.run = 1'b0;

        // Registered command outputs
        st_nxt.cmd.run_request   = st_nxt.run;
        st_nxt.cmd.reverse       = st_nxt.rev;
        st_nxt.cmd.pot_raise     = (cfg_i.run_scheme == SCHEME_RUN_PLUS_POT_RAISE)
                                   & lvl.second_run_input; // R16
        st_nxt.cmd.start_inhibit = ~lvl.run_enable
                                   | ((cfg_i.run_scheme == SCHEME_RUN_ENABLE) & ~lvl.second_run_input)
                                   | st_nxt.interlock;
        st_nxt.cmd.qs_pending    = (st_nxt.qs == QS_DELAY) || (st_nxt.qs == QS_WATCH);
        st_nxt.cmd.qs_bypass     = (st_nxt.qs == QS_BYPASS); // R05
        st_nxt.cmd.qs_own        = (st_nxt.qs == QS_OWN);
        st_nxt.cmd.force_speed_ctrl = (st_nxt.qs == QS_OWN); // R04
        st_nxt.cmd.ramp_sel      = (st_nxt.qs == QS_OWN) &&
                                   (cfg_i.quick_stop_mode == QS_MODE_RAMP); // R01
        st_nxt.cmd.limit_sel     = (st_nxt.qs == QS_OWN) &&
                                   (cfg_i.quick_stop_mode == QS_MODE_LIMITS); // R02
        st_nxt.cmd.ramp_time     = st_nxt.cmd.ramp_sel ? cfg_i.emergency_ramp_time : '0; // R01
        st_nxt.cmd.power_lim     = st_nxt.cmd.limit_sel ? cfg_i.emergency_power_cap : '0; // R02
        st_nxt.cmd.torque_lim    = st_nxt.cmd.limit_sel ? cfg_i.emergency_torque_cap : '0; // R02
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            st_r           <= '0;
            st_r.qs        <= QS_IDLE;
            // Power-up counts as a reason to demand an open start input
            st_r.interlock <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign cmd_o  = st_r.cmd;
    assign tick_o = tick;

endmodule

// ---- sim/dssq_plc_model.sv ----
// Model of the upper control system that answers a quick stop request
`timescale 1ns/1ps
module dssq_plc_model
    import dssq_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic tick_i,
    input  wire logic qs_i,
    input  wire logic ack_en_i,
    input  wire logic fall_en_i,
    output dssq_drv_t drv_o
);
    // 50 Hz at start, 0.1 Hz less per tick while braking
    localparam logic [VAL_W-1:0] FULL = 16'h1388;
    localparam logic [VAL_W-1:0] STEP = 16'h000A;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !qs_i)
        begin
            drv_o.out_freq <= FULL;
        end
        else if (tick_i && fall_en_i && drv_o.out_freq >= STEP)
        begin
            drv_o.out_freq <= drv_o.out_freq - STEP;
        end
        // Ack only while the stop request stands
        drv_o.aux_cmd_word <= {qs_i && ack_en_i && !sys_rst_i, 15'h0000};
    end
endmodule

// ---- sim/dssq_chk.sv ----
// Assertion checker for the start/stop and quick stop command logic
`timescale 1ns/1ps
module dssq_chk
    import dssq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    input wire logic      clk_sys_i,
    input wire logic      sys_rst_i,
    input wire dssq_din_t din_i,
    input wire dssq_cfg_t cfg_i,
    input wire dssq_drv_t drv_i,
    input wire dssq_cmd_t cmd_o,
    input wire logic      tick_o
);
    // ----
    // Tick spacing counter
    // ----
    logic [TCNT_W-1:0] gap_r;
    logic              seen_r;

    always_ff @(posedge clk_sys_i)
    begin
        gap_r  <= (sys_rst_i || tick_o) ? '0 : gap_r + 1'b1;
        seen_r <= !sys_rst_i && (seen_r || tick_o);
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_qs_rise;
        $rose(din_i.quick_stop) && !cmd_o.qs_pending && !cmd_o.qs_own && !cmd_o.qs_bypass;
    endsequence
    sequence s_qs_held;
        s_qs_rise ##1 din_i.quick_stop [*2];
    endsequence
    sequence s_fwd0;
        cfg_i.run_scheme == SCHEME_FWD_REV && din_i.first_run_input && !din_i.second_run_input
            && din_i.run_enable && !din_i.quick_stop;
    endsequence

    // ----
    // Properties
    // ----
    AST_QS_DELAY: assert property (s_qs_held |=> cmd_o.qs_pending)
        else $error("quick stop not pending after input");
    AST_SPEED: assert property (cmd_o.force_speed_ctrl == cmd_o.qs_own)
        else $error("speed control not tied to own stop");
    AST_EXCL: assert property (!(cmd_o.qs_own && cmd_o.qs_bypass))
        else $error("bypass and own stop together");
    AST_ACK_LOST: assert property ((cmd_o.qs_bypass && cfg_i.stop_supervision_select == SUP_ACK
        && !drv_i.aux_cmd_word[ACK_BIT]) |-> ##[1:3] cmd_o.qs_own)
        else $error("own stop missing after ack loss");
    AST_NONE: assert property ((cfg_i.stop_supervision_select == SUP_NONE) [*4] |-> !cmd_o.qs_bypass)
        else $error("bypass with no supervision");
    AST_RAMP: assert property ((cmd_o.qs_own && $past(cmd_o.qs_own) && $stable(cfg_i)
        && cfg_i.quick_stop_mode == QS_MODE_RAMP)
        |-> cmd_o.ramp_sel && cmd_o.ramp_time == cfg_i.emergency_ramp_time)
        else $error("emergency ramp not applied");
    AST_LIMITS: assert property ((cmd_o.qs_own && $past(cmd_o.qs_own) && $stable(cfg_i)
        && cfg_i.quick_stop_mode == QS_MODE_LIMITS) |-> cmd_o.limit_sel
        && cmd_o.power_lim == cfg_i.emergency_power_cap && cmd_o.torque_lim == cfg_i.emergency_torque_cap)
        else $error("emergency caps not applied");
    AST_TICK: assert property (tick_o && seen_r |-> gap_r == TCNT_W'(TICK_CYCLES - 1))
        else $error("tick spacing wrong");
    AST_RUN_EN: assert property (!din_i.run_enable [*3] |=> !cmd_o.run_request)
        else $error("run while run enable low");
    AST_FWD0: assert property (s_fwd0 [*4] |-> cmd_o.run_request && !cmd_o.reverse)
        else $error("forward start missing");
    AST_INHIBIT: assert property (($rose(din_i.fault_reset) && din_i.first_run_input)
        ##1 din_i.first_run_input [*3] |-> cmd_o.start_inhibit)
        else $error("no start inhibit after fault reset");
endmodule

bind dssq_core dssq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .din_i(din_i), .cfg_i(cfg_i), .drv_i(drv_i), .cmd_o(cmd_o), .tick_o(tick_o));

// ---- sim/test_dssq_core.sv ----
// Self-checking testbench of the start/stop and quick stop command logic
`timescale 1ns/1ps
module test_dssq_core;
    import dssq_pkg::*;

    // Short tick keeps quick stop waits short
    localparam int TCK = 10;
    logic      clk_sys_i = 1'b0;
    logic      sys_rst_i = 1'b1;
    logic      ack_en_r  = 1'b0;
    logic      fall_en_r = 1'b0;
    logic      tick_w;
    dssq_din_t din_r;
    dssq_cfg_t cfg_r;
    dssq_drv_t drv_w;
    dssq_cmd_t cmd_w;
    int        error_cnt = 0;
    int        tests_run = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    dssq_core #(.TICK_CYCLES(TCK)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .din_i(din_r),
        .cfg_i(cfg_r), .drv_i(drv_w), .cmd_o(cmd_w), .tick_o(tick_w));
    dssq_plc_model u_plc (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tick_i(tick_w),
        .qs_i(din_r.quick_stop), .ack_en_i(ack_en_r), .fall_en_i(fall_en_r), .drv_o(drv_w));

    // ----
    // Shared tasks
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic chk(input logic [VAL_W-1:0] seen, input logic [VAL_W-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic rr(input logic run, input logic rev);
        chk(cmd_w.run_request, run);
        chk(cmd_w.reverse, rev);
    endtask

    task automatic io(input logic f, input logic s, input logic r);
        din_r.first_run_input  <= f;
        din_r.second_run_input <= s;
        din_r.reverse          <= r;
        cyc(5);
    endtask

    task automatic qs_go(input logic [1:0] sel, input logic [1:0] mode, input logic ack, input logic fall);
        cfg_r.stop_supervision_select <= sel;
        cfg_r.quick_stop_mode         <= mode;
        ack_en_r                      <= ack;
        fall_en_r                     <= fall;
        cyc(2);
        din_r.quick_stop <= 1'b1;
        cyc(5);
    endtask

    task automatic qs_end;
        din_r.quick_stop <= 1'b0;
        cyc(5);
        chk(cmd_w.qs_own | cmd_w.qs_bypass | cmd_w.qs_pending, 1'b0);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_scheme0;
        cfg_r.run_scheme <= SCHEME_FWD_REV;
        io(1, 0, 0); rr(1, 0);
        io(0, 1, 0); rr(1, 1);
        io(1, 1, 0); rr(1, 1);
        io(0, 0, 0); chk(cmd_w.run_request, 1'b0);
        io(1, 1, 0); rr(1, 0);
        io(0, 0, 0);
    endtask

    task automatic t_scheme1_2;
        cfg_r.run_scheme <= SCHEME_RUN_DIR;
        io(1, 0, 0); rr(1, 0);
        io(1, 1, 0); rr(1, 1);
        io(0, 1, 0); chk(cmd_w.run_request, 1'b0);
        cfg_r.run_scheme <= SCHEME_RUN_ENABLE;
        io(1, 1, 1); rr(1, 1);
        io(1, 0, 1); chk(cmd_w.run_request, 1'b0);
        io(0, 0, 0);
    endtask

    task automatic t_scheme3_4;
        cfg_r.run_scheme <= SCHEME_THREE_WIRE_PULSE;
        io(1, 1, 0); chk(cmd_w.run_request, 1'b1);
        io(0, 1, 0); chk(cmd_w.run_request, 1'b1);
        io(0, 0, 0); chk(cmd_w.run_request, 1'b0);
        io(1, 0, 0); chk(cmd_w.run_request, 1'b0);
        cfg_r.run_scheme <= SCHEME_RUN_PLUS_POT_RAISE;
        io(1, 0, 0); rr(1, 0);
        chk(cmd_w.pot_raise, 1'b0);
        io(1, 1, 1); rr(1, 1);
        chk(cmd_w.pot_raise, 1'b1);
        io(0, 0, 0);
    endtask

    task automatic t_scheme5_6;
        cfg_r.run_scheme <= SCHEME_DUAL_DIRECTION_EDGE;
        io(1, 0, 0); rr(1, 0);
        din_r.run_enable <= 1'b0;
        cyc(5);
        chk(cmd_w.start_inhibit, 1'b1);
        din_r.run_enable <= 1'b1;
        cyc(5);
        chk(cmd_w.run_request, 1'b0);
        io(0, 0, 0); chk(cmd_w.start_inhibit, 1'b0);
        io(0, 1, 0); rr(1, 1);
        cfg_r.run_scheme <= SCHEME_EDGE_RUN_PLUS_DIRECTION;
        io(0, 0, 0);
        io(1, 1, 0); rr(1, 1);
        io(1, 0, 0); rr(1, 0);
        din_r.fault_reset <= 1'b1;
        cyc(5);
        din_r.fault_reset <= 1'b0;
        chk(cmd_w.start_inhibit, 1'b1);
        io(0, 0, 0); chk(cmd_w.run_request, 1'b0);
        io(1, 0, 0); rr(1, 0);
        din_r.place_change <= 1'b1;
        io(1, 0, 0); chk(cmd_w.start_inhibit, 1'b1);
        io(0, 0, 0);
    endtask

    task automatic t_qs_none;
        qs_go(SUP_NONE, QS_MODE_RAMP, 1'b1, 1'b1);
        chk(cmd_w.qs_pending, 1'b1);
        chk(cmd_w.qs_own, 1'b0);
        cyc(40);
        chk(cmd_w.qs_own, 1'b1);
        chk(cmd_w.ramp_time, cfg_r.emergency_ramp_time);
        qs_end;
        qs_go(SUP_NONE, QS_MODE_LIMITS, 1'b0, 1'b0);
        cyc(40);
        chk(cmd_w.power_lim, cfg_r.emergency_power_cap);
        chk(cmd_w.torque_lim, cfg_r.emergency_torque_cap);
        qs_end;
    endtask

    task automatic t_qs_ack;
        qs_go(SUP_ACK, QS_MODE_RAMP, 1'b1, 1'b0);
        cyc(40);
        chk(cmd_w.qs_bypass, 1'b1);
        ack_en_r <= 1'b0;
        cyc(5);
        chk(cmd_w.qs_own, 1'b1);
        qs_end;
        qs_go(SUP_ACK, QS_MODE_RAMP, 1'b0, 1'b1);
        cyc(200);
        chk(cmd_w.qs_own, 1'b0);
        cyc(150);
        chk(cmd_w.force_speed_ctrl, 1'b1);
        qs_end;
    endtask

    task automatic t_qs_freq;
        qs_go(SUP_FREQ, QS_MODE_RAMP, 1'b0, 1'b1);
        cyc(40);
        chk(cmd_w.qs_bypass, 1'b1);
        fall_en_r <= 1'b0;
        cyc(150);
        chk(cmd_w.qs_own, 1'b0);
        cyc(100);
        chk(cmd_w.qs_own, 1'b1);
        qs_end;
        qs_go(SUP_BOTH, QS_MODE_RAMP, 1'b1, 1'b0);
        cyc(40);
        chk(cmd_w.qs_bypass, 1'b0);
        qs_end;
        qs_go(SUP_BOTH, QS_MODE_RAMP, 1'b1, 1'b1);
        cyc(40);
        chk(cmd_w.qs_bypass, 1'b1);
        qs_end;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        cyc(20000);
        error_cnt++;
        report_and_stop;
    end

    initial
    begin
        din_r                      = '0;
        din_r.run_enable           = 1'b1;
        cfg_r                      = '0;
        cfg_r.stop_input_delay     = 16'h0002;
        cfg_r.stop_ack_timeout     = 16'h001E;
        cfg_r.emergency_ramp_time  = 16'h0123;
        cfg_r.emergency_power_cap  = 16'h0456;
        cfg_r.emergency_torque_cap = 16'h0789;
        cyc(3);
        sys_rst_i <= 1'b0;
        cyc(3);
        chk(cmd_w.start_inhibit, 1'b1);
        t_scheme0;
        t_scheme1_2;
        t_scheme3_4;
        t_scheme5_6;
        t_qs_none;
        t_qs_ack;
        t_qs_freq;
        report_and_stop;
    end
endmodule
